// ---- rtl/wcaac_pkg.sv ----
`default_nettype none
package wcaac_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Identify offsets are byte indices; each one takes a whole bus word
	localparam logic [ADDR_W-1:0] IDX_VOLATILE_CACHE_ATTR = 12'h20d;
	localparam logic [ADDR_W-1:0] IDX_NORMAL_ATOMIC_UNIT = 12'h20e;
	localparam logic [ADDR_W-1:0] IDX_POWERFAIL_ATOMIC_UNIT = 12'h210;
	localparam logic [ADDR_W-1:0] ADDR_VOLATILE_CACHE_ATTR =
		{IDX_VOLATILE_CACHE_ATTR[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_NORMAL_ATOMIC_UNIT =
		{IDX_NORMAL_ATOMIC_UNIT[ADDR_W-3:0], 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_POWERFAIL_ATOMIC_UNIT =
		{IDX_POWERFAIL_ATOMIC_UNIT[ADDR_W-3:0], 2'b00};

	// Command and namespace registers
	localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_NS_SEL = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_NS_NORMAL = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_NS_POWERFAIL = 12'h010;

	localparam int CACHE_PRESENT_BIT = 0;

	// 256 blocks of 512 bytes gives 128KB; both values are zero-based
	localparam logic [15:0] NORMAL_ATOMIC_VALUE = 16'h00ff;
	localparam logic [15:0] POWERFAIL_ATOMIC_VALUE = 16'h0007;
	localparam logic [15:0] POWERFAIL_ATOMIC_REPORTED =
		(POWERFAIL_ATOMIC_VALUE > NORMAL_ATOMIC_VALUE) ?
		NORMAL_ATOMIC_VALUE : POWERFAIL_ATOMIC_VALUE;

	localparam int NS_COUNT = 4;
	localparam int NS_IDX_W = 2;
	localparam logic [15:0] NS_UNIT_RESET = 16'h0000;

	localparam logic [7:0] OP_FLUSH = 8'h00;
	localparam logic [7:0] OP_WRITE = 8'h01;
	localparam logic [7:0] OP_READ = 8'h02;
	localparam logic [7:0] OP_SET_FEATURES = 8'h09;
	localparam logic [7:0] OP_GET_FEATURES = 8'h0a;
	localparam logic [7:0] FID_VOLATILE_CACHE = 8'h06;

	localparam logic [7:0] SC_SUCCESS = 8'h00;
	localparam logic [7:0] SC_INVALID_OPCODE = 8'h01;
	localparam logic [7:0] SC_INVALID_FIELD = 8'h02;

	// Status word layout
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_SC_LSB = 8;
	localparam int ST_ATOMIC = 16;
	localparam int ST_PF_SAFE = 17;
	localparam int ST_FEAT_VAL = 18;
	localparam int ST_CACHE_EN = 19;

	typedef struct packed {
		logic [15:0] nlb;
		logic [7:0] fid;
		logic [7:0] opcode;
	} wcaac_cmd_type;

	typedef struct packed {
		logic [7:0] status;
		logic atomic;
		logic pf_safe;
		logic feat_val;
	} wcaac_res_type;

	typedef enum logic [1:0] {
		S_IDLE,
		S_EVAL,
		S_FLUSH
	} wcaac_state_type;

endpackage
`default_nettype wire

// ---- rtl/wcaac_cmd_eval.sv ----
`default_nettype none
module wcaac_cmd_eval (
	input wire wcaac_pkg::wcaac_cmd_type cmd,
	input wire logic cache_present,
	input wire logic cache_en,
	input wire logic [15:0] eff_normal,
	input wire logic [15:0] eff_powerfail,
	output wcaac_pkg::wcaac_res_type res,
	output logic flush_go,
	output logic en_load,
	output logic en_val
);
	import wcaac_pkg::*;

	always_comb
	begin
		res = '0;
		res.status = SC_SUCCESS;
		flush_go = 1'b0;
		en_load = 1'b0;
		en_val = cache_en;
		case (cmd.opcode)
			OP_FLUSH:
			begin
				// Without a cache this completes at once with no effect
				flush_go = cache_present & cache_en;
			end
			OP_WRITE:
			begin
				// Both sides zero-based: nlb <= unit means N+1 blocks fit
				res.atomic = (cmd.nlb <= eff_normal);
				// All-ones unit makes every length atomic
				res.pf_safe = (cmd.nlb <= eff_powerfail);
				// pf_safe set: failure keeps old blocks
			end
			OP_READ:
			begin
				res.status = SC_SUCCESS;
			end
			OP_SET_FEATURES:
			begin
				if (cmd.fid != FID_VOLATILE_CACHE || !cache_present)
					res.status = SC_INVALID_FIELD;
				else
				begin
					en_load = 1'b1;
					en_val = cmd.nlb[0];
				end
			end
			OP_GET_FEATURES:
			begin
				if (cmd.fid != FID_VOLATILE_CACHE || !cache_present)
					res.status = SC_INVALID_FIELD;
				else
					res.feat_val = cache_en;
			end
			default:
			begin
				res.status = SC_INVALID_OPCODE;
			end
		endcase
	end

endmodule
`default_nettype wire

// ---- rtl/wcaac_top.sv ----
`default_nettype none
module wcaac_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wcaac_pkg::ADDR_W-1:0] paddr,
	input wire logic [wcaac_pkg::DATA_W-1:0] pwdata,
	output logic [wcaac_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cache_present_strap,
	input wire logic flush_done,
	output logic flush_req,
	output logic cache_enable
);
	import wcaac_pkg::*;

	wcaac_state_type state_q, state_d;
	wcaac_cmd_type cmd_q, cmd_d;
	wcaac_res_type res_q, res_d;
	wcaac_res_type eval_res;
	logic done_q, done_d;
	logic cache_en_q, cache_en_d;
	logic present_q, present_d;
	logic strap_taken_q, strap_taken_d;
	logic flush_req_q, flush_req_d;
	logic [NS_IDX_W-1:0] ns_sel_q, ns_sel_d;
	logic [DATA_W-1:0] prdata_q, prdata_d;
	logic [15:0] ns_normal_q [NS_COUNT];
	logic [15:0] ns_pf_q [NS_COUNT];
	logic [15:0] eff_normal, eff_powerfail, ns_normal_cur, ns_pf_cur;
	logic flush_go, en_load, en_val;
	logic wr_acc, rd_setup, addr_hit, cmd_wr;

	assign wr_acc = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign cmd_wr = wr_acc & (paddr == ADDR_CMD);

	// Zero wait states: every access finishes in its first access cycle
	assign pready = 1'b1;

	always_comb
	begin
		case (paddr)
			ADDR_VOLATILE_CACHE_ATTR, ADDR_NORMAL_ATOMIC_UNIT,
			ADDR_POWERFAIL_ATOMIC_UNIT, ADDR_CMD, ADDR_STATUS,
			ADDR_NS_SEL, ADDR_NS_NORMAL, ADDR_NS_POWERFAIL:
				addr_hit = 1'b1;
			default:
				addr_hit = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~addr_hit;
	assign prdata = prdata_q;
	assign flush_req = flush_req_q;
	assign cache_enable = cache_en_q;

	assign ns_normal_cur = ns_normal_q[ns_sel_q];
	assign ns_pf_cur = ns_pf_q[ns_sel_q];

	// A namespace can only widen the controller-wide guarantee
	always_comb
	begin
		eff_normal = (ns_normal_cur > NORMAL_ATOMIC_VALUE) ?
			ns_normal_cur : NORMAL_ATOMIC_VALUE;
		eff_powerfail = (ns_pf_cur > POWERFAIL_ATOMIC_REPORTED) ?
			ns_pf_cur : POWERFAIL_ATOMIC_REPORTED;
		// Power-fail unit may not outgrow the normal unit
		if (eff_powerfail > eff_normal)
			eff_powerfail = eff_normal;
	end

	wcaac_cmd_eval u_eval (
		.cmd(cmd_q),
		.cache_present(present_q),
		.cache_en(cache_en_q),
		.eff_normal(eff_normal),
		.eff_powerfail(eff_powerfail),
		.res(eval_res),
		.flush_go(flush_go),
		.en_load(en_load),
		.en_val(en_val)
	);

	// Command sequencer
	always_comb
	begin
		state_d = state_q;
		cmd_d = cmd_q;
		res_d = res_q;
		done_d = done_q;
		cache_en_d = cache_en_q;
		flush_req_d = flush_req_q;
		case (state_q)
			S_IDLE:
			begin
				// Writes to the command word while busy are dropped
				if (cmd_wr)
				begin
					cmd_d = wcaac_cmd_type'(pwdata);
					done_d = 1'b0;
					state_d = S_EVAL;
				end
			end
			S_EVAL:
			begin
				res_d = eval_res;
				if (en_load)
					cache_en_d = en_val;
				if (flush_go)
				begin
					flush_req_d = 1'b1;
					state_d = S_FLUSH;
				end
				else
				begin
					done_d = 1'b1;
					state_d = S_IDLE;
				end
			end
			S_FLUSH:
			begin
				if (flush_done)
				begin
					flush_req_d = 1'b0;
					done_d = 1'b1;
					state_d = S_IDLE;
				end
			end
			default:
			begin
				flush_req_d = 1'b0;
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_IDLE;
			cmd_q <= '0;
			res_q <= '0;
			done_q <= 1'b0;
			cache_en_q <= 1'b0;
			flush_req_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			res_q <= res_d;
			done_q <= done_d;
			cache_en_q <= cache_en_d;
			flush_req_q <= flush_req_d;
		end
	end

	// Presence strap is caught once, on the first edge after reset release
	always_comb
	begin
		present_d = present_q;
		strap_taken_d = 1'b1;
		if (!strap_taken_q)
			present_d = cache_present_strap;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			present_q <= 1'b0;
			strap_taken_q <= 1'b0;
		end
		else
		begin
			present_q <= present_d;
			strap_taken_q <= strap_taken_d;
		end
	end

	// Namespace select and per-namespace atomic units
	always_comb
	begin
		ns_sel_d = ns_sel_q;
		if (wr_acc && paddr == ADDR_NS_SEL)
			ns_sel_d = pwdata[NS_IDX_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ns_sel_q <= '0;
		else
			ns_sel_q <= ns_sel_d;
	end

	for (genvar g = 0; g < NS_COUNT; g++)
	begin : g_ns
		logic [15:0] norm_d, pf_d;
		logic sel;
		assign sel = (ns_sel_q == NS_IDX_W'(g));
		always_comb
		begin
			norm_d = ns_normal_q[g];
			pf_d = ns_pf_q[g];
			if (wr_acc && sel && paddr == ADDR_NS_NORMAL)
				norm_d = pwdata[15:0];
			if (wr_acc && sel && paddr == ADDR_NS_POWERFAIL)
				pf_d = pwdata[15:0];
		end
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				ns_normal_q[g] <= NS_UNIT_RESET;
				ns_pf_q[g] <= NS_UNIT_RESET;
			end
			else
			begin
				ns_normal_q[g] <= norm_d;
				ns_pf_q[g] <= pf_d;
			end
		end
	end

	// Read data is captured in the setup cycle so it is a flop output
	always_comb
	begin
		prdata_d = prdata_q;
		if (rd_setup)
		begin
			prdata_d = '0;
			case (paddr)
				ADDR_VOLATILE_CACHE_ATTR:
					prdata_d[CACHE_PRESENT_BIT] = present_q;
				ADDR_NORMAL_ATOMIC_UNIT:
					prdata_d[15:0] = NORMAL_ATOMIC_VALUE;
				ADDR_POWERFAIL_ATOMIC_UNIT:
					prdata_d[15:0] = POWERFAIL_ATOMIC_REPORTED;
				ADDR_CMD:
					prdata_d = cmd_q;
				ADDR_STATUS:
				begin
					prdata_d[ST_BUSY] = (state_q != S_IDLE);
					prdata_d[ST_DONE] = done_q;
					prdata_d[ST_SC_LSB +: 8] = res_q.status;
					prdata_d[ST_ATOMIC] = res_q.atomic;
					prdata_d[ST_PF_SAFE] = res_q.pf_safe;
					prdata_d[ST_FEAT_VAL] = res_q.feat_val;
					prdata_d[ST_CACHE_EN] = cache_en_q;
				end
				ADDR_NS_SEL:
					prdata_d[NS_IDX_W-1:0] = ns_sel_q;
				ADDR_NS_NORMAL:
					prdata_d[15:0] = ns_normal_cur;
				ADDR_NS_POWERFAIL:
					prdata_d[15:0] = ns_pf_cur;
				default:
					prdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_q <= '0;
		else
			prdata_q <= prdata_d;
	end

endmodule
`default_nettype wire

// ---- verif/wcaac_cache_model.sv ----
`default_nettype none
module wcaac_cache_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] delay,
	input wire logic flush_req,
	output logic flush_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_q;
	// Done is a single pulse, the least forgiving answer the block takes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 4'h0;
			flush_done <= 1'b0;
		end
		else if (!flush_req)
		begin
			cnt_q <= 4'h0;
			flush_done <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			flush_done <= (cnt_q == delay);
		end
	end
endmodule
`default_nettype wire

// ---- verif/wcaac_top_sva.sv ----
`default_nettype none
module wcaac_top_sva
	import wcaac_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cache_present_strap,
	input wire logic flush_done,
	input wire logic flush_req,
	input wire logic cache_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic acc;
	logic rd;
	logic mapped;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	assign mapped = paddr inside {ADDR_CMD, ADDR_STATUS, ADDR_NS_SEL,
		ADDR_NS_NORMAL, ADDR_NS_POWERFAIL, ADDR_VOLATILE_CACHE_ATTR,
		ADDR_NORMAL_ATOMIC_UNIT, ADDR_POWERFAIL_ATOMIC_UNIT};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_unmapped: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr wrong for address");
	a_err_access: assert property (pslverr |-> acc)
		else $error("pslverr outside access");
	a_rdata_unmapped: assert property (rd && !mapped |-> prdata == '0)
		else $error("unmapped read data not zero");
	a_attr_reserved: assert property (rd && paddr ==
		ADDR_VOLATILE_CACHE_ATTR |-> prdata[31:1] == '0)
		else $error("cache attr reserved bits set");
	a_normal_unit: assert property (rd && paddr ==
		ADDR_NORMAL_ATOMIC_UNIT |-> prdata == 32'(NORMAL_ATOMIC_VALUE))
		else $error("normal unit wrong");
	a_pf_unit: assert property (rd && paddr ==
		ADDR_POWERFAIL_ATOMIC_UNIT |->
		prdata <= 32'(NORMAL_ATOMIC_VALUE))
		else $error("power-fail unit above normal");
	a_flush_hold: assert property (flush_req && !flush_done
		|=> flush_req)
		else $error("flush request dropped early");
	a_flush_drop: assert property (flush_req && flush_done
		|=> !flush_req)
		else $error("flush request held after done");
	a_flush_absent: assert property (flush_req |-> cache_enable)
		else $error("flush request without enabled cache");
	a_enable_strap: assert property (cache_enable
		|-> cache_present_strap)
		else $error("cache enabled while absent");
endmodule
bind wcaac_top wcaac_top_sva u_sva (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .cache_present_strap,
	.flush_done, .flush_req, .cache_enable);
`default_nettype wire

// ---- verif/wcaac_top_tb.sv ----
`default_nettype none
module wcaac_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import wcaac_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic strap = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, flush_done, flush_req, cache_enable;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int flushes = 0;
	logic [31:0] st;
	wcaac_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cache_present_strap(strap),
		.flush_done, .flush_req, .cache_enable);
	wcaac_cache_model u_cache (.pclk, .presetn, .delay(dly), .flush_req,
		.flush_done);
	initial
	begin
		forever #25 pclk = ~pclk;
	end
	always @(posedge flush_req) flushes++;
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rst(input logic s);
		presetn <= 1'b0;
		strap <= s;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// Each call waits one edge first so that no signal is set twice at once
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only pready high or the bench timeout ends this wait
		do
		begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [11:0] a,
		input logic [31:0] ex, input logic ee);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, ex, r);
		chk("pslverr", 32'(ee), 32'(e));
	endtask
	task automatic cmd(input logic [7:0] op, fid, input logic [15:0] nlb,
		input logic [9:0] ex);
		logic e;
		int n = 0;
		apb(1'b1, ADDR_CMD, {nlb, fid, op}, st, e);
		do
		begin
			apb(1'b0, ADDR_STATUS, 32'h0, st, e);
			n++;
		end while (st[ST_DONE] !== 1'b1 && n < 40);
		chk("done", 32'h1, 32'(st[ST_DONE]));
		chk("status", 32'(ex), 32'(st[17:8]));
	endtask
	task automatic t_absent();
		logic [31:0] r;
		logic e;
		rst(1'b0);
		rdc("attr", ADDR_VOLATILE_CACHE_ATTR, 32'h0, 1'b0);
		apb(1'b1, ADDR_VOLATILE_CACHE_ATTR, 32'hffff_ffff, r, e);
		rdc("attr", ADDR_VOLATILE_CACHE_ATTR, 32'h0, 1'b0);
		rdc("normal", ADDR_NORMAL_ATOMIC_UNIT, 32'h0000_00ff, 1'b0);
		rdc("pf", ADDR_POWERFAIL_ATOMIC_UNIT, 32'h0000_0007, 1'b0);
		rdc("hole", 12'h100, 32'h0, 1'b1);
		cmd(OP_FLUSH, 8'h00, 16'h0000, {2'b00, SC_SUCCESS});
		cmd(OP_SET_FEATURES, FID_VOLATILE_CACHE, 16'h0001,
			{2'b00, SC_INVALID_FIELD});
		cmd(OP_GET_FEATURES, FID_VOLATILE_CACHE, 16'h0000,
			{2'b00, SC_INVALID_FIELD});
		cmd(8'h7f, 8'h00, 16'h0000, {2'b00, SC_INVALID_OPCODE});
		chk("flushes", 32'h0, 32'(flushes));
		chk("cache_enable", 32'h0, 32'(cache_enable));
	endtask
	task automatic t_present();
		rst(1'b1);
		rdc("attr", ADDR_VOLATILE_CACHE_ATTR, 32'h1, 1'b0);
		cmd(OP_SET_FEATURES, FID_VOLATILE_CACHE, 16'h0001,
			{2'b00, SC_SUCCESS});
		chk("cache_enable", 32'h1, 32'(cache_enable));
		cmd(OP_GET_FEATURES, FID_VOLATILE_CACHE, 16'h0000,
			{2'b00, SC_SUCCESS});
		chk("feat_val", 32'h1, 32'(st[ST_FEAT_VAL]));
		chk("st cache_en", 32'h1, 32'(st[ST_CACHE_EN]));
		// Any other feature id is refused even with a cache fitted
		cmd(OP_SET_FEATURES, 8'h05, 16'h0000, {2'b00, SC_INVALID_FIELD});
		dly <= 4'h9;
		cmd(OP_FLUSH, 8'h00, 16'h0000, {2'b00, SC_SUCCESS});
		dly <= 4'h0;
		cmd(OP_FLUSH, 8'h00, 16'h0000, {2'b00, SC_SUCCESS});
		chk("flushes", 32'h2, 32'(flushes));
		cmd(OP_SET_FEATURES, FID_VOLATILE_CACHE, 16'h0000,
			{2'b00, SC_SUCCESS});
		cmd(OP_FLUSH, 8'h00, 16'h0000, {2'b00, SC_SUCCESS});
		chk("flushes", 32'h2, 32'(flushes));
	endtask
	task automatic t_atomic();
		logic [31:0] r;
		logic e;
		// Boundaries either side of each zero-based unit
		cmd(OP_WRITE, 8'h00, 16'h00ff, 10'h100);
		cmd(OP_WRITE, 8'h00, 16'h0100, 10'h000);
		cmd(OP_WRITE, 8'h00, 16'h0007, 10'h300);
		cmd(OP_WRITE, 8'h00, 16'h0008, 10'h100);
		apb(1'b1, ADDR_NS_SEL, 32'h1, r, e);
		apb(1'b1, ADDR_NS_NORMAL, 32'hffff, r, e);
		apb(1'b1, ADDR_NS_POWERFAIL, 32'hffff, r, e);
		rdc("ns normal", ADDR_NS_NORMAL, 32'hffff, 1'b0);
		cmd(OP_WRITE, 8'h00, 16'hffff, 10'h300);
		// Namespace power-fail unit above its normal unit must be clamped
		apb(1'b1, ADDR_NS_SEL, 32'h2, r, e);
		apb(1'b1, ADDR_NS_NORMAL, 32'h0200, r, e);
		apb(1'b1, ADDR_NS_POWERFAIL, 32'h0300, r, e);
		cmd(OP_WRITE, 8'h00, 16'h0200, 10'h300);
		cmd(OP_WRITE, 8'h00, 16'h0201, 10'h000);
		cmd(OP_READ, 8'h00, 16'h0000, {2'b00, SC_SUCCESS});
	endtask
	initial
	begin
		t_absent();
		t_present();
		t_atomic();
		tally_and_finish();
	end
endmodule
`default_nettype wire
